/* core/cdu_params.svh */
// Functional notes
// - in-range code passes, else clamped to limit
// - low limit above high limit tri-states buffer
// - limit registers restored by startup load
// - every setting held in two latch stages
// - load starts only after supply passes lockout
// - fill all first latches, then copy together
// - fixed delay, then first state word loaded
// - accesses before load done are not-acknowledged
// - update bit 0 set makes writes immediate
// - update bit 0 clear writes first stage only
// - update bit 1 pulse copies all stages
// - store rewrites leave running configuration alone
// - page erase sets ones only when enabled
// - own state store, 64-bit words, 63 states
// - state fetch on advance takes ten microseconds
// - software edits state words in store directly
// - first write byte loads the pointer
// - user reload bit 0 triggers reload
// - software erases a location before writing it
`ifndef CDU_PARAMS_SVH
`define CDU_PARAMS_SVH
`define CDU_CLK_NS 100
`define CDU_SE_DELAY_NS 500000
`define CDU_SE_DELAY_CYC ((`CDU_SE_DELAY_NS + `CDU_CLK_NS - 1) / `CDU_CLK_NS)
`define CDU_FETCH_NS 10000
`define CDU_FETCH_CYC (`CDU_FETCH_NS / `CDU_CLK_NS)
`define CDU_NCH 6
`define CDU_NV_BASE 8'h40
`define CDU_UPD_ADDR 8'h90
`define CDU_STAT_ADDR 8'h91
`define CDU_RELOAD_ADDR 8'hd8
`define CDU_SEQ_IDX_ADDR 8'he0
`define CDU_SEQ_BASE 8'he8
`define CDU_ERASE_ADDR 8'hfe
`define CDU_UPD_TRANSP 0
`define CDU_UPD_COPY 1
`define CDU_UPD_ERASE 2
`define CDU_RELOAD_BIT 0
`define CDU_BLANK 8'hff
`define CDU_SEQ_WORDS 64
`define CDU_SEQ_RSVD 6'h3f
`endif

/* core/cdu_pkg.sv */
package cdu_pkg;
  typedef enum logic [1:0] {
    CDU_K_PTR = 2'b00,
    CDU_K_WR = 2'b01,
    CDU_K_RD = 2'b10,
    CDU_K_NONE = 2'b11
  } cdu_kind_t;
  typedef enum logic [2:0] {
    CDU_L_WAIT = 3'b000,
    CDU_L_LOAD = 3'b001,
    CDU_L_XFER = 3'b010,
    CDU_L_DELAY = 3'b011,
    CDU_L_FETCH = 3'b100,
    CDU_L_RUN = 3'b101
  } cdu_load_t;
  typedef enum logic [1:0] {
    CDU_H_IDLE = 2'b00,
    CDU_H_PTR = 2'b01,
    CDU_H_DATA = 2'b10,
    CDU_H_WAIT = 2'b11
  } cdu_host_t;
endpackage

/* core/cdu_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface cdu_link_if (
  input wire logic clock
);
  import cdu_pkg::*;
  logic link_valid;
  cdu_kind_t link_kind;
  logic [7:0] link_data;
  logic dev_ack;
  logic dev_nack;
  logic dev_rvalid;
  logic [7:0] dev_rdata;
  modport dev_mp (
    input link_valid, link_kind, link_data,
    output dev_ack, dev_nack, dev_rvalid, dev_rdata
  );
  modport host_mp (
    output link_valid, link_kind, link_data,
    input dev_ack, dev_nack, dev_rvalid, dev_rdata
  );
endinterface
`default_nettype wire

/* core/cdu_device.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cdu_params.svh"
module cdu_device #(
  parameter int NCH = `CDU_NCH,
  parameter int DLY_CYC = `CDU_SE_DELAY_CYC,
  parameter int FETCH_CYC = `CDU_FETCH_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // link to the bus master
  cdu_link_if.dev_mp link,
  // supply comparator, asynchronous
  input wire logic supply_ok,
  // sequencing engine
  input wire logic se_advance,
  input wire logic [5:0] se_next_index,
  output logic [63:0] se_state_word,
  output logic [5:0] se_state_index,
  output logic se_fetch_busy,
  // margining converters
  output logic [NCH*8-1:0] dac_code,
  output logic [NCH-1:0] dac_drive_en,
  // status
  output logic config_loaded
);
  import cdu_pkg::*;
  localparam int NCFG = 3 * NCH;
  localparam int CW = $clog2(NCFG + 1);
  localparam int DW = $clog2(DLY_CYC + FETCH_CYC + 1);

  ////////////////////////////////////////////////////////////////
  // supply input synchroniser
  logic sup_s1, sup_s2, sup_s3, sup_ok;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sup_s1 <= 1'b0;
      sup_s2 <= 1'b0;
      sup_s3 <= 1'b0;
      sup_ok <= 1'b0;
    end else begin
      sup_s1 <= supply_ok;
      sup_s2 <= sup_s1;
      sup_s3 <= sup_s2;
      if (sup_s2 == sup_s3) begin
        sup_ok <= sup_s3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] nv_cfg [NCFG];
  logic [63:0] nv_seq [`CDU_SEQ_WORDS];
  logic [7:0] latch_a [NCFG];
  logic [7:0] latch_b [NCFG];
  logic [7:0] upd_ctrl;
  logic [7:0] pointer;
  logic [5:0] seq_idx;
  cdu_load_t state;
  logic [CW-1:0] load_idx;
  logic [DW-1:0] cnt;
  logic reload_run;
  logic reload_req;

  ////////////////////////////////////////////////////////////////
  // link decode
  wire acc = link.link_valid && config_loaded;
  wire wr = acc && (link.link_kind == CDU_K_WR);
  wire rd = acc && (link.link_kind == CDU_K_RD);
  wire [7:0] wd = link.link_data;
  wire hit_cfg = pointer < 8'(NCFG);
  wire hit_nv = (pointer >= `CDU_NV_BASE) && (pointer < `CDU_NV_BASE + 8'(NCFG));
  wire hit_seq = (pointer >= `CDU_SEQ_BASE) && (pointer < `CDU_SEQ_BASE + 8'h08);
  wire [CW-1:0] cfg_idx = CW'(pointer);
  wire [CW-1:0] nv_idx = CW'(pointer - `CDU_NV_BASE);
  wire [2:0] seq_byte = pointer[2:0];
  wire wr_cfg = wr && hit_cfg;
  wire wr_nv = wr && hit_nv;
  wire wr_seq = wr && hit_seq;
  wire wr_upd = wr && (pointer == `CDU_UPD_ADDR);
  wire transparent = upd_ctrl[`CDU_UPD_TRANSP];
  wire copy_pulse = wr_upd && wd[`CDU_UPD_COPY];
  wire erase_cmd = wr && (pointer == `CDU_ERASE_ADDR) && upd_ctrl[`CDU_UPD_ERASE];
  wire reload_cmd = wr && (pointer == `CDU_RELOAD_ADDR) && wd[`CDU_RELOAD_BIT];
  wire load_wr = (state == CDU_L_LOAD);
  wire xfer_all = (state == CDU_L_XFER) || copy_pulse;
  wire load_last = load_idx == CW'(NCFG - 1);
  wire cnt_done = cnt == '0;

  assign link.dev_ack = acc && (link.link_kind != CDU_K_NONE);
  assign link.dev_nack = link.link_valid && !config_loaded;

  ////////////////////////////////////////////////////////////////
  // double-buffered configuration latches
  generate
    for (genvar i = 0; i < NCFG; i++) begin : g_latch
      wire host_hit = wr_cfg && (cfg_idx == CW'(i));
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          latch_a[i] <= 8'h00;
          latch_b[i] <= 8'h00;
        end else begin
          if (load_wr && load_idx == CW'(i)) begin
            latch_a[i] <= nv_cfg[i];
          end else if (host_hit) begin
            latch_a[i] <= wd;
          end
          if (xfer_all) begin
            latch_b[i] <= latch_a[i];
          end else if (host_hit && transparent) begin
            latch_b[i] <= wd;
          end
        end
      end
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          nv_cfg[i] <= `CDU_BLANK;
        end else if (erase_cmd) begin
          nv_cfg[i] <= `CDU_BLANK;
        end else if (wr_nv && nv_idx == CW'(i)) begin
          nv_cfg[i] <= nv_cfg[i] & wd;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // sequencing state store
  generate
    for (genvar w = 0; w < `CDU_SEQ_WORDS; w++) begin : g_seq
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          nv_seq[w] <= {8{`CDU_BLANK}};
        end else if (erase_cmd && seq_idx == 6'(w)) begin
          nv_seq[w] <= {8{`CDU_BLANK}};
        end else if (wr_seq && seq_idx == 6'(w)) begin
          nv_seq[w][seq_byte*8 +: 8] <= nv_seq[w][seq_byte*8 +: 8] & wd;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // pointer, control registers, read data
  wire [7:0] status = {5'h00, reload_run, se_fetch_busy, config_loaded};
  wire [7:0] rd_mux =
    hit_cfg ? latch_a[cfg_idx] :
    hit_nv ? nv_cfg[nv_idx] :
    hit_seq ? nv_seq[seq_idx][seq_byte*8 +: 8] :
    (pointer == `CDU_UPD_ADDR) ? upd_ctrl :
    (pointer == `CDU_STAT_ADDR) ? status :
    (pointer == `CDU_SEQ_IDX_ADDR) ? {2'b00, seq_idx} : 8'h00;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pointer <= 8'h00;
      upd_ctrl <= 8'h00;
      seq_idx <= 6'h00;
      link.dev_rvalid <= 1'b0;
      link.dev_rdata <= 8'h00;
    end else begin
      if (acc && link.link_kind == CDU_K_PTR) begin
        pointer <= wd;
      end
      if (wr_upd) begin
        upd_ctrl <= {5'h00, wd[`CDU_UPD_ERASE], 1'b0, wd[`CDU_UPD_TRANSP]};
      end
      if (wr && pointer == `CDU_SEQ_IDX_ADDR) begin
        seq_idx <= wd[5:0];
      end
      link.dev_rvalid <= rd;
      if (rd) begin
        link.dev_rdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // load and state-fetch sequencer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= CDU_L_WAIT;
      load_idx <= '0;
      cnt <= '0;
      config_loaded <= 1'b0;
      reload_run <= 1'b0;
      reload_req <= 1'b0;
      se_state_word <= 64'h0;
      se_state_index <= 6'h00;
      se_fetch_busy <= 1'b0;
    end else begin
      if (reload_cmd) begin
        reload_req <= 1'b1;
      end
      case (state)
        CDU_L_WAIT: begin
          if (sup_ok) begin
            state <= CDU_L_LOAD;
            load_idx <= '0;
          end
        end
        CDU_L_LOAD: begin
          load_idx <= load_idx + CW'(1);
          if (load_last) begin
            state <= CDU_L_XFER;
          end
        end
        CDU_L_XFER: begin
          config_loaded <= 1'b1;
          if (reload_run) begin
            reload_run <= 1'b0;
            state <= CDU_L_RUN;
          end else begin
            cnt <= DW'(DLY_CYC - 1);
            state <= CDU_L_DELAY;
          end
        end
        CDU_L_DELAY: begin
          cnt <= cnt - DW'(1);
          if (cnt_done) begin
            se_state_index <= 6'h00;
            cnt <= DW'(FETCH_CYC - 1);
            se_fetch_busy <= 1'b1;
            state <= CDU_L_FETCH;
          end
        end
        CDU_L_FETCH: begin
          cnt <= cnt - DW'(1);
          if (cnt_done) begin
            se_state_word <= nv_seq[se_state_index];
            se_fetch_busy <= 1'b0;
            state <= CDU_L_RUN;
          end
        end
        CDU_L_RUN: begin
          if (reload_req && !reload_cmd) begin
            reload_req <= 1'b0;
            reload_run <= 1'b1;
            load_idx <= '0;
            state <= CDU_L_LOAD;
          end else if (se_advance && se_next_index != `CDU_SEQ_RSVD) begin
            se_state_index <= se_next_index;
            cnt <= DW'(FETCH_CYC - 1);
            se_fetch_busy <= 1'b1;
            state <= CDU_L_FETCH;
          end
        end
        default: begin
          state <= CDU_L_WAIT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // margining code clamp per channel
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_clamp
      wire [7:0] code = latch_b[c];
      wire [7:0] lo = latch_b[NCH + c];
      wire [7:0] hi = latch_b[2 * NCH + c];
      wire [7:0] clamped = (code < lo) ? lo : (code > hi) ? hi : code;
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          dac_code[c*8 +: 8] <= 8'h00;
          dac_drive_en[c] <= 1'b0;
        end else begin
          dac_code[c*8 +: 8] <= clamped;
          dac_drive_en[c] <= config_loaded && (lo <= hi);
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* core/cdu_host.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cdu_params.svh"
module cdu_host (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // link to the device
  cdu_link_if.host_mp link,
  // user command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_commit,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_nack,
  output logic [7:0] rsp_rdata
);
  import cdu_pkg::*;
  cdu_host_t state;
  logic is_write;
  logic [7:0] addr;
  logic [7:0] wdata;

  ////////////////////////////////////////////////////////////////
  // link drive
  wire in_ptr = state == CDU_H_PTR;
  wire in_data = state == CDU_H_DATA;
  assign cmd_ready = state == CDU_H_IDLE;
  assign link.link_valid = in_ptr || in_data;
  assign link.link_kind = in_ptr ? CDU_K_PTR : in_data ? (is_write ? CDU_K_WR : CDU_K_RD) :
                          CDU_K_NONE;
  assign link.link_data = in_ptr ? addr : wdata;

  ////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= CDU_H_IDLE;
      is_write <= 1'b0;
      addr <= 8'h00;
      wdata <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_nack <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        CDU_H_IDLE: begin
          if (cmd_valid) begin
            is_write <= cmd_write || cmd_commit;
            addr <= cmd_commit ? `CDU_UPD_ADDR : cmd_addr;
            wdata <= cmd_commit ? (cmd_wdata | (8'h01 << `CDU_UPD_COPY)) : cmd_wdata;
            state <= CDU_H_PTR;
          end
        end
        CDU_H_PTR: begin
          if (link.dev_nack) begin
            rsp_valid <= 1'b1;
            rsp_nack <= 1'b1;
            state <= CDU_H_IDLE;
          end else begin
            state <= CDU_H_DATA;
          end
        end
        CDU_H_DATA: begin
          if (link.dev_nack || is_write) begin
            rsp_valid <= 1'b1;
            rsp_nack <= link.dev_nack;
            state <= CDU_H_IDLE;
          end else begin
            state <= CDU_H_WAIT;
          end
        end
        CDU_H_WAIT: begin
          if (link.dev_rvalid) begin
            rsp_valid <= 1'b1;
            rsp_nack <= 1'b0;
            rsp_rdata <= link.dev_rdata;
            state <= CDU_H_IDLE;
          end
        end
        default: begin
          state <= CDU_H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* bench/cdu_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cdu_params.svh"
module cdu_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // link signals
  input wire logic link_valid,
  input wire cdu_pkg::cdu_kind_t link_kind,
  input wire logic [7:0] link_data,
  input wire logic dev_ack,
  input wire logic dev_nack,
  input wire logic dev_rvalid,
  input wire logic [7:0] dev_rdata
);
  import cdu_pkg::*;
  logic acked;
  wire rd_ack = link_valid && link_kind == CDU_K_RD && dev_ack;
  wire wr_ack = link_valid && link_kind == CDU_K_WR && dev_ack;
  wire is_ptr = link_valid && link_kind == CDU_K_PTR;
  wire upd_ptr = is_ptr && link_data == `CDU_UPD_ADDR;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // remembers that the device has acknowledged once
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) acked <= 1'b0;
    else if (dev_ack) acked <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_ACK_XOR: assert property (link_valid |-> !(dev_ack && dev_nack))
    else $error("ack and nack together");
  AST_IDLE_QUIET: assert property (!link_valid |-> !dev_ack && !dev_nack)
    else $error("answer without request");
  AST_ANSWERED: assert property (link_valid && link_kind != CDU_K_NONE |-> dev_ack || dev_nack)
    else $error("request left unanswered");
  AST_NO_NACK_AFTER_LOAD: assert property (acked |-> !dev_nack)
    else $error("nack after load");
  AST_READ_ANSWER: assert property (rd_ack |=> dev_rvalid ##1 !dev_rvalid)
    else $error("read not answered in one cycle");
  AST_RVALID_CAUSE: assert property (dev_rvalid |-> $past(rd_ack))
    else $error("read data without read");
  AST_RDATA_HOLD: assert property (!dev_rvalid |-> $stable(dev_rdata))
    else $error("read data changed");
  AST_PTR_FIRST: assert property (wr_ack |-> $past(is_ptr))
    else $error("data byte without pointer");
  AST_NACK_NO_READ: assert property (link_valid && dev_nack |=> !dev_rvalid)
    else $error("refused read answered");
  ////////////////////////////////////////////////////////////////////////////////
  CV_READ: cover property (rd_ack);
  CV_NACK: cover property (link_valid && dev_nack);
  CV_WRITE: cover property (wr_ack);
  CV_UPD_WRITE: cover property (upd_ptr && dev_ack ##1 wr_ack);
endmodule
`default_nettype wire

/* bench/cdu_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cdu_params.svh"
`define CDU_CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module cdu_bench;
  import cdu_pkg::*;
  localparam int DLY = 20;
  localparam int FCY = 5;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic supply_ok = 1'b0;
  logic se_advance = 1'b0;
  logic [5:0] se_next_index = 6'h00;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic cmd_commit = 1'b0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [63:0] se_state_word;
  logic [5:0] se_state_index;
  logic se_fetch_busy, config_loaded, cmd_ready, rsp_valid, rsp_nack;
  logic [`CDU_NCH*8-1:0] dac_code;
  logic [`CDU_NCH-1:0] dac_drive_en;
  logic [7:0] rsp_rdata;
  logic [7:0] cin [4] = '{8'h05, 8'h10, 8'hf1, 8'h80};
  logic [7:0] cex [4] = '{8'h10, 8'h10, 8'hf0, 8'h80};
  int err_count = 0;
  int n_tests = 0;
  int n;
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #50 clock = ~clock;
  end
  cdu_link_if u_cdu_link_if (.clock(clock));
  cdu_device #(.NCH(`CDU_NCH), .DLY_CYC(DLY), .FETCH_CYC(FCY)) u_cdu_device (
    .clock(clock), .reset_n(reset_n), .link(u_cdu_link_if), .supply_ok(supply_ok),
    .se_advance(se_advance), .se_next_index(se_next_index), .se_state_word(se_state_word),
    .se_state_index(se_state_index), .se_fetch_busy(se_fetch_busy), .dac_code(dac_code),
    .dac_drive_en(dac_drive_en), .config_loaded(config_loaded));
  cdu_host u_cdu_host (
    .clock(clock), .reset_n(reset_n), .link(u_cdu_link_if), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_commit(cmd_commit), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata));
  cdu_assertions u_cdu_assertions (
    .clock(clock), .reset_n(reset_n), .link_valid(u_cdu_link_if.link_valid),
    .link_kind(u_cdu_link_if.link_kind), .link_data(u_cdu_link_if.link_data),
    .dev_ack(u_cdu_link_if.dev_ack), .dev_nack(u_cdu_link_if.dev_nack),
    .dev_rvalid(u_cdu_link_if.dev_rvalid), .dev_rdata(u_cdu_link_if.dev_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic op(input logic w, input logic c, input logic [7:0] a, input logic [7:0] d);
    int k = 0;
    @(negedge clock);
    while (cmd_ready !== 1'b1 && k < 50) begin
      @(negedge clock);
      k++;
    end
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_commit = c;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge clock);
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 50) begin
      @(negedge clock);
      k++;
    end
    `CDU_CHK(rsp_valid, 1'b1)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    op(1'b0, 1'b0, a, 8'h00);
    `CDU_CHK(rsp_nack, 1'b0)
    `CDU_CHK(rsp_rdata, e)
  endtask
  task automatic step(input logic [5:0] idx);
    int k = 0;
    @(negedge clock);
    se_next_index = idx;
    se_advance = 1'b1;
    @(negedge clock);
    se_advance = 1'b0;
    while (se_fetch_busy !== 1'b1 && k < 20) begin
      @(negedge clock);
      k++;
    end
    k = 0;
    while (se_fetch_busy !== 1'b0 && k < 20) begin
      @(negedge clock);
      k++;
    end
  endtask
  task automatic results;
    $display("errors %0d compares %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    err_count++;
    results();
  end
  initial begin
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    op(1'b0, 1'b0, 8'h00, 8'h00);
    `CDU_CHK(rsp_nack, 1'b1)
    repeat (30) @(negedge clock);
    `CDU_CHK(config_loaded, 1'b0)
    `CDU_CHK(dac_drive_en, {`CDU_NCH{1'b0}})
    supply_ok = 1'b1;
    n = 0;
    while (config_loaded !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    `CDU_CHK(config_loaded, 1'b1)
    n = 0;
    while (se_fetch_busy !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    `CDU_CHK((n >= DLY - 1 && n <= DLY + 2), 1'b1)
    n = 0;
    while (se_fetch_busy !== 1'b0 && n < 100) begin
      @(negedge clock);
      n++;
    end
    `CDU_CHK((n >= FCY - 1 && n <= FCY + 2), 1'b1)
    `CDU_CHK(se_state_word, {64{1'b1}})
    `CDU_CHK(dac_drive_en, {`CDU_NCH{1'b1}})
    rd(8'h00, 8'hff);
    rd(`CDU_STAT_ADDR, 8'h01);
    rd(8'h30, 8'h00);
    wr(`CDU_UPD_ADDR, 8'h00);
    wr(8'h00, 8'h80);
    wr(8'h06, 8'h10);
    wr(8'h0c, 8'hf0);
    repeat (3) @(negedge clock);
    `CDU_CHK(dac_code[7:0], 8'hff)
    rd(8'h00, 8'h80);
    op(1'b1, 1'b1, `CDU_UPD_ADDR, 8'h00);
    repeat (2) @(negedge clock);
    `CDU_CHK(dac_code[7:0], 8'h80)
    wr(`CDU_UPD_ADDR, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, cin[i]);
      repeat (2) @(negedge clock);
      `CDU_CHK(dac_code[7:0], cex[i])
    end
    wr(8'h07, 8'h90);
    wr(8'h0d, 8'h20);
    repeat (2) @(negedge clock);
    `CDU_CHK(dac_drive_en[1:0], 2'b01)
    wr(`CDU_NV_BASE, 8'h33);
    repeat (2) @(negedge clock);
    `CDU_CHK(dac_code[7:0], 8'h80)
    rd(`CDU_NV_BASE, 8'h33);
    wr(`CDU_RELOAD_ADDR, 8'h01);
    n = 0;
    while (dac_drive_en[1] !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    repeat (2) @(negedge clock);
    `CDU_CHK(dac_drive_en[1], 1'b1)
    `CDU_CHK(dac_code[7:0], 8'hff)
    rd(8'h00, 8'h33);
    wr(`CDU_SEQ_IDX_ADDR, 8'h01);
    wr(`CDU_SEQ_BASE, 8'h5a);
    step(`CDU_SEQ_RSVD);
    `CDU_CHK(se_state_index, 6'h00)
    step(6'h01);
    `CDU_CHK(se_state_word, {56'hff_ffff_ffff_ffff, 8'h5a})
    `CDU_CHK(se_state_index, 6'h01)
    wr(`CDU_ERASE_ADDR, 8'h00);
    rd(`CDU_NV_BASE, 8'h33);
    wr(`CDU_UPD_ADDR, 8'h05);
    wr(`CDU_ERASE_ADDR, 8'h00);
    rd(`CDU_NV_BASE, 8'hff);
    step(6'h01);
    `CDU_CHK(se_state_word, {64{1'b1}})
    results();
  end
endmodule
`default_nettype wire
